// ==== inc/via_pkg.sv ====
// shared constants and types of the vectored interrupt arbiter
`default_nettype none
package via_pkg;
    localparam int          NUM_MASKABLE   = 13;
    localparam int          RANK_W         = 4;
    localparam logic [15:0] SERVICE_ENTRY  = 16'h00FF;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [7:0]  SP_RESET       = 8'h6F;
    localparam logic [3:0]  RANK_DEFAULT   = 4'h0;
    localparam logic [3:0]  RANK_TRAP      = 4'hF;
    localparam int          ACK_CYCLES     = 7;
    localparam logic [2:0]  ACK_LAST       = 3'(ACK_CYCLES - 1);
    localparam logic [2:0]  ACK_PUSH_LO    = 3'h1;
    localparam logic [2:0]  ACK_PUSH_HI    = 3'h2;
    localparam logic [2:0]  ACK_CNT_ZERO   = 3'h0;
    localparam logic [12:0] MASK_ZERO      = 13'h0000;

    typedef enum logic [1:0] {
        VIA_RUN,
        VIA_ACK
    } via_state_e;
endpackage
`default_nettype wire

// ==== hw/via_rank_encoder.sv ====
// fixed priority encoder over the thirteen maskable sources
`default_nettype none
module via_rank_encoder (
    // enabled pending requests, bit 0 lowest rank
    input  wire logic [12:0] req_in,
    // rank index, default rank when none
    output logic      [3:0]  rank_out,
    output logic             any_out
);
    logic [3:0] rank_w [0:13];

    assign rank_w[0] = via_pkg::RANK_DEFAULT;

    genvar g;
    generate
        for (g = 0; g < 13; g++) begin : g_rank
            // higher bit overrides lower: fixed rank
            assign rank_w[g+1] = req_in[g] ? 4'(g + 1) : rank_w[g];
        end
    endgenerate

    assign rank_out = rank_w[13];
    assign any_out  = |req_in;
endmodule
`default_nettype wire

// ==== hw/via_arbiter.sv ====
// interrupt arbitration, pending/enable state and acknowledge sequencer
// Behaviour
// - fourteen interrupt sources: thirteen maskable plus the software trap.
// - every accepted interrupt loads the program counter with 00FF hex.
// - software trap ranks highest; default vector-select entry ranks lowest.
// - each maskable source has a fixed rank and vector position.
// - all but the trap maskable, each with enable and pending bits.
// - pending bit sets on source event whatever its enable.
// - enables are readable and writable, pending bits readable and clearable by software.
// - maskable request needs enable, global enable and no trap service.
// - trap service holds off every maskable request until it returns.
// - conditions sampled only at instruction start, all must hold then.
// - simultaneous requests: highest rank served first, others stay pending.
// - reset clears pending, enables and global enable.
// - acknowledge clears global enable, pushes return address, loads 00FF.
// - acknowledge sequence lasts seven instruction cycles.
// - return from interrupt sets global enable and restores program counter.
// - a pending skip is done before an interrupt is acknowledged.
`default_nettype none
module via_arbiter (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // instruction-cycle enable from the core divider
    input  wire logic        cycle_en_in,
    // sequencer handshakes
    input  wire logic        insn_start_in,
    input  wire logic        skip_pending_in,
    input  wire logic        trap_insn_in,
    input  wire logic        return_from_irq_instruction_in,
    input  wire logic [15:0] next_pc_in,
    input  wire logic [15:0] stack_pc_in,
    // peripheral events, one-cycle pulses
    input  wire logic [12:0] event_in,
    // software access to control bits
    input  wire logic        enable_wr_in,
    input  wire logic [12:0] enable_wdata_in,
    input  wire logic        pending_clr_in,
    input  wire logic [12:0] pending_clr_mask_in,
    input  wire logic        gie_wr_in,
    input  wire logic        gie_wdata_in,
    // status to software and vector-select instruction
    output logic      [12:0] enable_out,
    output logic      [12:0] pending_out,
    output logic             global_irq_enable_out,
    output logic      [3:0]  vector_rank_out,
    // core control
    output logic             ack_busy_out,
    output logic             ack_done_out,
    output logic             push_en_out,
    output logic      [7:0]  push_data_out,
    output logic             pc_load_out,
    output logic      [15:0] pc_out,
    output logic             trap_active_out
);
    logic              rst_meta_reg;
    logic              rst_sync_reg;
    logic [12:0]       pending_reg;
    logic [12:0]       enable_reg;
    logic              gie_reg;
    logic              trap_act_reg;
    logic              trap_req_reg;
    logic [15:0]       ret_pc_reg;
    logic [15:0]       pc_reg;
    logic              pc_load_reg;
    logic              push_en_reg;
    logic [7:0]        push_data_reg;
    logic [2:0]        ack_cnt_reg;
    logic [3:0]        rank_reg;
    via_pkg::via_state_e state_reg;

    logic [12:0]       pending_next;
    logic [12:0]       active_w;
    logic [12:0]       qualify_w;
    logic [3:0]        enc_rank_w;
    logic              enc_any_w;
    logic              maskable_ok_w;
    logic              sample_w;
    logic              launch_w;
    logic              ack_end_w;
    logic              gie_next;

    // reset release through two flip-flops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_n = rst_sync_reg;

    // set wins over software clear
    assign pending_next = (pending_reg & ~(pending_clr_in ? pending_clr_mask_in : via_pkg::MASK_ZERO))
                          | event_in;

    // maskable qualify terms
    assign maskable_ok_w = gie_reg && !trap_act_reg && !trap_req_reg;
    assign active_w      = pending_reg & enable_reg;
    assign qualify_w     = active_w & {13{maskable_ok_w}};

    // ranks enabled pending sources; vector select runs with global enable off
    via_rank_encoder u_enc (
        .req_in   (active_w),
        .rank_out (enc_rank_w),
        .any_out  (enc_any_w)
    );

    via_rank_lowest_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (active_w == via_pkg::MASK_ZERO) |-> (enc_rank_w == via_pkg::RANK_DEFAULT))
        else $error("rank not default with no request");

    // sampling only at instruction start, after any skip
    assign sample_w  = cycle_en_in && insn_start_in && !skip_pending_in && state_reg == via_pkg::VIA_RUN;
    assign launch_w  = sample_w && ((enc_any_w && maskable_ok_w) || trap_insn_in);
    assign ack_end_w = state_reg == via_pkg::VIA_ACK && cycle_en_in && ack_cnt_reg == via_pkg::ACK_LAST;

    // global enable: acknowledge clears, return sets, software writes
    assign gie_next = launch_w ? 1'b0 :
                      (cycle_en_in && return_from_irq_instruction_in) ? 1'b1 :
                      gie_wr_in ? gie_wdata_in : gie_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pending_reg <= via_pkg::MASK_ZERO;
            enable_reg  <= via_pkg::MASK_ZERO;
            gie_reg     <= 1'b0;
        end else if (!rst_n) begin
            pending_reg <= via_pkg::MASK_ZERO;
            enable_reg  <= via_pkg::MASK_ZERO;
            gie_reg     <= 1'b0;
        end else begin
            pending_reg <= pending_next;
            enable_reg  <= enable_wr_in ? enable_wdata_in : enable_reg;
            gie_reg     <= gie_next;
        end
    end

    // trap request and active service tracking
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trap_req_reg <= 1'b0;
            trap_act_reg <= 1'b0;
        end else if (!rst_n) begin
            trap_req_reg <= 1'b0;
            trap_act_reg <= 1'b0;
        end else begin
            trap_req_reg <= launch_w && trap_insn_in;
            if (launch_w && trap_insn_in) begin
                trap_act_reg <= 1'b1;
            end else if (cycle_en_in && return_from_irq_instruction_in) begin
                trap_act_reg <= 1'b0;
            end
        end
    end

    // acknowledge sequencer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg   <= via_pkg::VIA_RUN;
            ack_cnt_reg <= via_pkg::ACK_CNT_ZERO;
            ret_pc_reg  <= via_pkg::PC_RESET;
        end else if (!rst_n) begin
            state_reg   <= via_pkg::VIA_RUN;
            ack_cnt_reg <= via_pkg::ACK_CNT_ZERO;
            ret_pc_reg  <= via_pkg::PC_RESET;
        end else begin
            unique case (state_reg)
                via_pkg::VIA_RUN: begin
                    if (launch_w) begin
                        state_reg   <= via_pkg::VIA_ACK;
                        ack_cnt_reg <= via_pkg::ACK_CNT_ZERO;
                        ret_pc_reg  <= next_pc_in;
                    end
                end
                via_pkg::VIA_ACK: begin
                    if (cycle_en_in) begin
                        ack_cnt_reg <= ack_cnt_reg + 3'h1;
                        if (ack_end_w) begin
                            state_reg <= via_pkg::VIA_RUN;
                        end
                    end
                end
            endcase
        end
    end

    // push strobes, pc load, rank register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            push_en_reg   <= 1'b0;
            push_data_reg <= 8'h00;
            pc_load_reg   <= 1'b0;
            pc_reg        <= via_pkg::PC_RESET;
            rank_reg      <= via_pkg::RANK_DEFAULT;
        end else if (!rst_n) begin
            push_en_reg   <= 1'b0;
            push_data_reg <= 8'h00;
            pc_load_reg   <= 1'b0;
            pc_reg        <= via_pkg::PC_RESET;
            rank_reg      <= via_pkg::RANK_DEFAULT;
        end else begin
            push_en_reg   <= state_reg == via_pkg::VIA_ACK && cycle_en_in
                             && (ack_cnt_reg == via_pkg::ACK_PUSH_LO || ack_cnt_reg == via_pkg::ACK_PUSH_HI);
            push_data_reg <= (ack_cnt_reg == via_pkg::ACK_PUSH_LO) ? ret_pc_reg[7:0] : ret_pc_reg[15:8];
            pc_load_reg   <= ack_end_w || (cycle_en_in && return_from_irq_instruction_in);
            if (ack_end_w) begin
                pc_reg <= via_pkg::SERVICE_ENTRY;
            end else if (cycle_en_in && return_from_irq_instruction_in) begin
                pc_reg <= stack_pc_in;
            end
            // trap highest, encoder otherwise
            rank_reg <= trap_act_reg ? via_pkg::RANK_TRAP : enc_rank_w;
        end
    end

    assign enable_out            = enable_reg;
    assign pending_out           = pending_reg;
    assign global_irq_enable_out = gie_reg;
    assign vector_rank_out       = rank_reg;
    assign ack_busy_out          = state_reg == via_pkg::VIA_ACK;
    assign ack_done_out          = ack_end_w;
    assign push_en_out           = push_en_reg;
    assign push_data_out         = push_data_reg;
    assign pc_load_out           = pc_load_reg;
    assign pc_out                = pc_reg;
    assign trap_active_out       = trap_act_reg;

    // assertions
    pend_set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (event_in != via_pkg::MASK_ZERO) |=> ((pending_reg & $past(event_in)) == $past(event_in)))
        else $error("event lost from pending");
    reset_clear_a: assert property (@(posedge clk_in) $rose(rst_n) |->
        (pending_reg == via_pkg::MASK_ZERO && enable_reg == via_pkg::MASK_ZERO && !gie_reg))
        else $error("state not cleared by reset");
    no_gie_launch_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (sample_w && !gie_reg && !trap_insn_in) |=> state_reg == via_pkg::VIA_RUN)
        else $error("launch without global enable");
    trap_holdoff_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (trap_act_reg && sample_w && !trap_insn_in) |=> state_reg == via_pkg::VIA_RUN)
        else $error("maskable launched during trap");
    start_only_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_reg == via_pkg::VIA_RUN && !(cycle_en_in && insn_start_in)) |=> state_reg == via_pkg::VIA_RUN)
        else $error("launch outside instruction start");
    skip_first_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_reg == via_pkg::VIA_RUN && skip_pending_in) |=> state_reg == via_pkg::VIA_RUN)
        else $error("acknowledge before skip");
    gie_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        launch_w |=> !gie_reg)
        else $error("global enable kept on acknowledge");
    entry_load_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        ack_end_w |=> (pc_load_reg && pc_reg == via_pkg::SERVICE_ENTRY))
        else $error("entry address not loaded");
    return_from_irq_instruction_gie_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (cycle_en_in && return_from_irq_instruction_in && !launch_w) |=> (gie_reg && pc_reg == $past(stack_pc_in)))
        else $error("return did not restore");
    ack_len_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(state_reg == via_pkg::VIA_ACK) |-> (state_reg == via_pkg::VIA_ACK) until ack_end_w)
        else $error("acknowledge cut short");
    trap_rank_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        trap_act_reg |=> rank_reg == via_pkg::RANK_TRAP)
        else $error("trap rank not highest");

    ack_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n) ack_end_w);
    trap_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n) launch_w && trap_insn_in);
    multi_req_c: cover property (@(posedge clk_in) disable iff (!rst_n) sample_w && $countones(qualify_w) > 1);
    return_from_irq_instruction_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n) cycle_en_in && return_from_irq_instruction_in);
endmodule
`default_nettype wire

// ==== verification/via_core_model.sv ====
// core sequencer stand-in: instruction-cycle enables and sequencer strobes
`default_nettype none
module via_core_model #(
    parameter int DIV = 4
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // bench requests
    input  wire logic run_in,
    input  wire logic skip_req_in,
    input  wire logic trap_req_in,
    input  wire logic return_from_irq_instruction_req_in,
    // sequencer strobes
    output logic      cycle_en_out,
    output logic      insn_start_out,
    output logic      skip_pending_out,
    output logic      trap_insn_out,
    output logic      return_from_irq_instruction_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_reg;
    // divider moves off the sampling edge
    always @(negedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 0;
        end else begin
            cnt_reg <= (cnt_reg == DIV - 1) ? 0 : cnt_reg + 1;
        end
    end
    // a return instruction is not a start at which a launch may happen
    assign cycle_en_out     = run_in && (cnt_reg == 0);
    assign insn_start_out   = cycle_en_out && !return_from_irq_instruction_req_in;
    assign skip_pending_out = cycle_en_out && skip_req_in;
    assign trap_insn_out    = insn_start_out && trap_req_in;
    assign return_from_irq_instruction_out         = cycle_en_out && return_from_irq_instruction_req_in;
endmodule
`default_nettype wire

// ==== verification/tb_via_arbiter.sv ====
// self-checking bench of the interrupt arbiter
`default_nettype none
module tb_via_arbiter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rstn_in, cyc, ins, skp, trp, ret, run, skip_req, trap_req, return_from_irq_instruction_req;
    logic [15:0] next_pc, stack_pc, pc_out, pc_seen;
    logic [12:0] ev, en_wd, clr_m, en_o, pend_o;
    logic en_wr, clr, g_wr, g_wd, g_o, busy, done, push_en, pc_ld, trap_act;
    logic [3:0] rank;
    logic [7:0] push_d;
    logic [7:0] push_q[$];
    int error_cnt, compares, loads, en_cnt, ack_len;
    logic [12:0] a, b;

    initial begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end

    via_core_model i_via_core_model (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run),
        .skip_req_in(skip_req), .trap_req_in(trap_req), .return_from_irq_instruction_req_in(return_from_irq_instruction_req), .cycle_en_out(cyc),
        .insn_start_out(ins), .skip_pending_out(skp), .trap_insn_out(trp), .return_from_irq_instruction_out(ret));

    via_arbiter i_via_arbiter (.clk_in(clk_in), .rstn_in(rstn_in), .cycle_en_in(cyc), .insn_start_in(ins),
        .skip_pending_in(skp), .trap_insn_in(trp), .return_from_irq_instruction_in(ret), .next_pc_in(next_pc),
        .stack_pc_in(stack_pc), .event_in(ev), .enable_wr_in(en_wr), .enable_wdata_in(en_wd),
        .pending_clr_in(clr), .pending_clr_mask_in(clr_m), .gie_wr_in(g_wr), .gie_wdata_in(g_wd),
        .enable_out(en_o), .pending_out(pend_o), .global_irq_enable_out(g_o), .vector_rank_out(rank),
        .ack_busy_out(busy), .ack_done_out(done), .push_en_out(push_en), .push_data_out(push_d),
        .pc_load_out(pc_ld), .pc_out(pc_out), .trap_active_out(trap_act));

    // observe acknowledge length, pushes and program-counter loads
    always @(posedge clk_in) begin
        if (!busy) en_cnt = 0;
        else if (cyc) en_cnt++;
        if (done) ack_len = en_cnt;
        if (push_en) push_q.push_back(push_d);
        if (pc_ld) begin
            pc_seen = pc_out;
            loads++;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [3:0] exp_rank(input logic [12:0] q);
        exp_rank = 4'h0;
        for (int i = 0; i < 13; i++) if (q[i]) exp_rank = 4'(i + 1);
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic wr_en(input logic [12:0] m);
        en_wr = 1;
        en_wd = m;
        step(1);
        en_wr = 0;
    endtask

    task automatic clr_p(input logic [12:0] m);
        clr = 1;
        clr_m = m;
        step(1);
        clr = 0;
    endtask

    task automatic set_glob(input logic v);
        g_wr = 1;
        g_wd = v;
        step(1);
        g_wr = 0;
    endtask

    task automatic pulse_ev(input logic [12:0] m);
        ev = m;
        step(1);
        ev = 13'h0000;
    endtask

    task automatic wait_load;
        int n0;
        n0 = loads;
        for (int k = 0; k < 300 && loads == n0; k++) step(1);
        check(16'(loads - n0), 16'h0001, "pc load count");
    endtask

    task automatic end_sim;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #200us;
        error_cnt++;
        end_sim();
    end

    initial begin
        {rstn_in, run, skip_req, trap_req, return_from_irq_instruction_req, en_wr, clr, g_wr, g_wd} = '0;
        {ev, en_wd, clr_m} = '0;
        next_pc = 16'h0000;
        stack_pc = 16'h0000;
        void'($urandom(15278));
        step(20);
        rstn_in = 1;
        step(3);
        check(16'(en_o), 16'h0000, "enable reset");
        check(16'(pend_o), 16'h0000, "pending reset");
        check(16'(g_o), 16'h0000, "global reset");
        a = 13'($urandom) | 13'h0001;
        pulse_ev(a);
        step(2);
        check(16'(pend_o), 16'(a), "pending while disabled");
        check(16'(rank), 16'h0000, "rank with none");
        wr_en(13'h0001);
        run = 1;
        step(20);
        check(16'(loads), 16'h0000, "no launch without global");
        run = 0;
        set_glob(1);
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 13'h1FFF : 13'($urandom);
            b = (i == 1) ? 13'h0001 : 13'($urandom);
            clr_p(13'h1FFF);
            wr_en(a);
            check(16'(en_o), 16'(a), "enable write");
            pulse_ev(b);
            step(2);
            check(16'(rank), 16'(exp_rank(a & b)), "rank");
        end
        clr_p(13'h1FFF);
        wr_en(13'h0011);
        pulse_ev(13'h0011);
        next_pc = 16'($urandom);
        push_q.delete();
        run = 1;
        wait_load();
        check(pc_seen, 16'h00FF, "entry");
        check(16'(g_o), 16'h0000, "global after ack");
        check(16'(ack_len), 16'h0007, "ack length");
        check(16'(push_q.size()), 16'h0002, "push count");
        check(16'({push_q[1], push_q[0]}), next_pc, "pushed pc");
        check(16'(rank), 16'h0005, "served rank");
        check(16'(pend_o), 16'h0011, "others pending");
        clr_p(13'h0010);
        stack_pc = 16'($urandom);
        return_from_irq_instruction_req = 1;
        wait_load();
        return_from_irq_instruction_req = 0;
        check(pc_seen, stack_pc, "return pc");
        check(16'(g_o), 16'h0001, "global after return");
        wait_load();
        check(pc_seen, 16'h00FF, "next pending served");
        check(16'(rank), 16'h0001, "next rank");
        return_from_irq_instruction_req = 1;
        wait_load();
        return_from_irq_instruction_req = 0;
        skip_req = 1;
        a = 13'(loads);
        step(40);
        check(16'(busy), 16'h0000, "no ack on skip");
        check(16'(loads), 16'(a), "no load on skip");
        skip_req = 0;
        wait_load();
        check(pc_seen, 16'h00FF, "ack after skip");
        clr_p(13'h1FFF);
        return_from_irq_instruction_req = 1;
        wait_load();
        return_from_irq_instruction_req = 0;
        trap_req = 1;
        wait_load();
        trap_req = 0;
        check(16'(trap_act), 16'h0001, "trap active");
        check(16'(rank), 16'h000F, "trap rank");
        set_glob(1);
        pulse_ev(13'h0001);
        a = 13'(loads);
        step(60);
        check(16'(loads), 16'(a), "maskable held off");
        return_from_irq_instruction_req = 1;
        wait_load();
        return_from_irq_instruction_req = 0;
        wait_load();
        check(16'(trap_act), 16'h0000, "trap over");
        check(pc_seen, 16'h00FF, "maskable after trap");
        end_sim();
    end
endmodule
`default_nettype wire
